// ===== design/mcp_menu_params.sv
// mcp_menu_params: menu, settings and midi interpretation of a midi-to-cv unit
// assumes decoded midi bytes on clk, classic wishbone master, raw button pins
// Contract
// [RULE1] wait about one second before converting
// [RULE2] once ready, gate, reset, clock lamps work; gate_led follows ready here, not the gate
// [RULE3] six menus plus version, no wrap
// [RULE4] enter opens up to nine parameters
// [RULE5] enter edits; long hold accelerates steps
// [RULE6] escape climbs one level per press
// [RULE7] changes act on outputs at once
// [RULE8] settings volatile until stored
// [RULE9] channel 1 to 15, default 1
// [RULE10] reference note 12 to 72, default 24
// [RULE11] glide 0 to 100, default 0
// [RULE12] bend range 0 to 60, default 12
// [RULE13] highest or last held note wins
// [RULE14] curve hz per volt or volt/octave
// [RULE15] gain trim coarse, then fine, 0-126
// [RULE16] offset trim two-step, default zero volts
// [RULE17] aux source velocity, bend, pressure, controller
// [RULE18] gate polarity high or low
// [RULE19] retrigger gap 0 to 20 ms
// [RULE20] clock menu holds two parameters
// [RULE21] clock divisor 1 to 61, default 1
// [RULE22] editing saturates at limits
//
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`default_nettype none
module mcp_menu_params #(
    parameter int POWERUP_CYCLES  = mcp_pkg::POWERUP_CYC,
    parameter int HOLD_CYCLES     = mcp_pkg::HOLD_CYC,
    parameter int REPEAT_CYCLES   = mcp_pkg::REPEAT_CYC,
    parameter int MS_CYCLES       = mcp_pkg::CYC_PER_MS,
    parameter int CLKPULSE_CYCLES = mcp_pkg::CLKPULSE_CYC
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [3:0]  btn_pins,      // inc, dec, enter, escape
    input  wire logic        midi_valid,
    input  wire logic [7:0]  midi_status,
    input  wire logic [6:0]  midi_data1,
    input  wire logic [6:0]  midi_data2,
    output logic             ready,
    output logic             show_version,
    output logic             gate_led,
    output logic             clock_led,
    output logic             reset_led,
    output logic [6:0]       pitch_note,
    output logic [13:0]      pitch_bend,
    output logic [6:0]       aux_voltage_out,
    output logic             gate_out,
    output logic             clock_out,
    output logic             reset_out,
    output logic [2:0]       menu_level
);
    logic [7:0]  prm [mcp_pkg::NSLOT];
    mcp_pkg::mcp_level_t level;
    logic [2:0]   menu;
    logic [3:0]   param;
    logic         fine;
    logic [3:0]   btn;
    logic         inc_p, dec_p, ent_p, esc_p;
    logic [3:0]   cur;
    logic [31:0]  power_cnt;
    logic [127:0] held;
    logic [6:0]   last_note, hi_note;
    logic         last_valid;
    logic [31:0]  gap_cnt, pulse_cnt;
    logic [5:0]   div_cnt;
    logic [7:0]   chan_idx;
    logic         chan_ok, note_on, note_off, tick, wrap, gate_core;
    logic         bus_req, bus_wr;
    logic [7:0]   woff;
    logic [31:0]  next_rdata;

    // one synchroniser and repeat generator per button
    for (genvar i = 0; i < 4; i++) begin : g_btn
        mcp_button #(
            .HOLD_CYCLES  (HOLD_CYCLES),
            .REPEAT_CYCLES(REPEAT_CYCLES)
        ) u_btn (
            .clk  (clk),
            .reset(reset),
            .pin  (btn_pins[i]),
            .press(btn[i])
        );
    end
    assign inc_p = btn[0] && !btn[1];
    assign dec_p = btn[1] && !btn[0];
    assign ent_p = btn[2];
    assign esc_p = btn[3];
    assign cur   = mcp_pkg::slot_of(menu, param, fine);

    // power-up idle while the version shows
    always_ff @(posedge clk) begin
        if (reset) begin
            power_cnt <= 32'h0;
            ready     <= 1'b0;
        end else if (!ready) begin
            if (power_cnt == 32'(POWERUP_CYCLES - 1)) ready <= 1'b1; // RULE1
            else power_cnt <= power_cnt + 32'h1;
        end
    end

    // menu walk: top, parameter and value levels
    always_ff @(posedge clk) begin
        if (reset) begin
            level <= mcp_pkg::LVL_TOP;
            menu  <= 3'h0;
            param <= 4'h0;
            fine  <= 1'b0;
        end else if (ready) begin
            case (level)
                mcp_pkg::LVL_TOP: begin
                    if (ent_p && mcp_pkg::param_count(menu) != 4'h0) begin
                        level <= mcp_pkg::LVL_PARAM; // RULE4
                        param <= 4'h0;
                    end else if (inc_p && menu != mcp_pkg::MENU_LAST) menu <= menu + 3'h1; // RULE3
                    else if (dec_p && menu != 3'h0) menu <= menu - 3'h1; // RULE3
                end
                mcp_pkg::LVL_PARAM: begin
                    if (esc_p) level <= mcp_pkg::LVL_TOP; // RULE6
                    else if (ent_p) begin
                        level <= mcp_pkg::LVL_VALUE; // RULE5
                        fine  <= 1'b0; // RULE15 RULE16
                    end else if (inc_p && param != mcp_pkg::param_count(menu) - 4'h1) param <= param + 4'h1; // RULE4
                    else if (dec_p && param != 4'h0) param <= param - 4'h1; // RULE4 RULE20
                end
                mcp_pkg::LVL_VALUE: begin
                    if (esc_p) begin
                        level <= mcp_pkg::LVL_PARAM; // RULE6
                        fine  <= 1'b0;
                    end else if (ent_p && menu == 3'h0 && (param == 4'h6 || param == 4'h7)) begin
                        fine <= 1'b1; // RULE15 RULE16
                    end
                end
                default: level <= mcp_pkg::LVL_TOP;
            endcase
        end
    end
    assign menu_level = level;

    // settings live only in these flops; reset brings defaults back
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < mcp_pkg::NSLOT; i++) begin
                prm[i] <= mcp_pkg::slot_default(4'(i)); // RULE8 RULE9 RULE10 RULE11 RULE12 RULE14 RULE21
            end
        end else if (bus_wr) begin
            prm[woff[5:2]] <= mcp_pkg::clamp(woff[5:2], wb_dat_i[7:0]);
        end else if (ready && level == mcp_pkg::LVL_VALUE) begin
            if (inc_p && prm[cur] < mcp_pkg::slot_max(cur)) prm[cur] <= prm[cur] + 8'h01; // RULE22
            else if (dec_p && prm[cur] > mcp_pkg::slot_min(cur)) prm[cur] <= prm[cur] - 8'h01; // RULE22
        end
    end

    // channel filter on channel voice messages
    assign chan_idx = prm[mcp_pkg::S_CHAN] - 8'h01;
    assign chan_ok  = midi_valid && ready && midi_status[7:4] != 4'hf
                      && midi_status[3:0] == chan_idx[3:0]; // RULE9
    assign note_on  = chan_ok && midi_status[7:4] == mcp_pkg::MS_ON && midi_data2 != 7'h0;
    assign note_off = chan_ok && (midi_status[7:4] == mcp_pkg::MS_OFF
                      || (midi_status[7:4] == mcp_pkg::MS_ON && midi_data2 == 7'h0));
    assign tick     = midi_valid && ready && midi_status == mcp_pkg::RT_CLK;

    function automatic logic [6:0] highest(input logic [127:0] h);
        highest = 7'h0;
        for (int i = 0; i < 128; i++) begin
            if (h[i]) highest = 7'(i);
        end
    endfunction
    assign hi_note = highest(held);

    // held keys and most recent key
    always_ff @(posedge clk) begin
        if (reset) begin
            held       <= 128'h0;
            last_note  <= 7'h0;
            last_valid <= 1'b0;
        end else if (note_on) begin
            held[midi_data1] <= 1'b1;
            last_note        <= midi_data1;
            last_valid       <= 1'b1;
        end else if (note_off) begin
            held[midi_data1] <= 1'b0;
            if (midi_data1 == last_note) last_valid <= 1'b0;
        end
    end

    // note priority picks the sounding note
    always_ff @(posedge clk) begin
        if (reset) pitch_note <= 7'h0;
        else if (prm[mcp_pkg::S_MODE][0] && last_valid) pitch_note <= last_note; // RULE13
        else if (held != 128'h0) pitch_note <= hi_note; // RULE13
    end

    // retrigger gap after a key pressed over a held key
    always_ff @(posedge clk) begin
        if (reset) gap_cnt <= 32'h0;
        else if (note_on && held != 128'h0 && prm[mcp_pkg::S_RTRG] != 8'h0)
            gap_cnt <= 32'(prm[mcp_pkg::S_RTRG]) * 32'(MS_CYCLES); // RULE19
        else if (gap_cnt != 32'h0) gap_cnt <= gap_cnt - 32'h1;
    end
    assign gate_core = held != 128'h0 && gap_cnt == 32'h0;

    // gate with selectable sense, lamps
    always_ff @(posedge clk) begin
        if (reset) begin
            gate_out     <= 1'b0;
            gate_led     <= 1'b0;
            show_version <= 1'b1;
        end else begin
            gate_out     <= (ready && gate_core) ^ prm[mcp_pkg::S_GPOL][0]; // RULE18 RULE7
            gate_led     <= ready; // RULE2
            show_version <= !ready; // RULE1
        end
    end

    // clock divider and output pulse
    assign wrap = tick && div_cnt >= prm[mcp_pkg::S_CDIV][5:0] - 6'h1;
    always_ff @(posedge clk) begin
        if (reset) div_cnt <= 6'h0;
        else if (wrap) div_cnt <= 6'h0; // RULE21
        else if (tick) div_cnt <= div_cnt + 6'h1;
    end
    always_ff @(posedge clk) begin
        if (reset) pulse_cnt <= 32'h0;
        else if (wrap) pulse_cnt <= 32'(CLKPULSE_CYCLES);
        else if (pulse_cnt != 32'h0) pulse_cnt <= pulse_cnt - 32'h1;
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            clock_out <= 1'b0;
            clock_led <= 1'b0;
        end else begin
            clock_out <= (pulse_cnt != 32'h0) ^ prm[mcp_pkg::S_CPOL][0]; // RULE20 RULE7
            clock_led <= pulse_cnt != 32'h0; // RULE2
        end
    end

    // transport state drives reset output
    always_ff @(posedge clk) begin
        if (reset) reset_out <= 1'b0;
        else if (midi_valid && ready) begin
            if (midi_status == mcp_pkg::RT_START || midi_status == mcp_pkg::RT_CONT) reset_out <= 1'b0;
            else if (midi_status == mcp_pkg::RT_STOP) reset_out <= 1'b1;
        end
    end
    assign reset_led = reset_out; // RULE2

    // bend value and aux source selection
    always_ff @(posedge clk) begin
        if (reset) pitch_bend <= 14'h2000;
        else if (chan_ok && midi_status[7:4] == mcp_pkg::MS_BEND) pitch_bend <= {midi_data2, midi_data1};
    end
    always_ff @(posedge clk) begin
        if (reset) aux_voltage_out <= 7'h0;
        else if (chan_ok) begin
            case (prm[mcp_pkg::S_AUX])
                8'h00: if (note_on) aux_voltage_out <= midi_data2; // RULE17
                8'h01: if (midi_status[7:4] == mcp_pkg::MS_BEND) aux_voltage_out <= midi_data2;
                8'h02: if (midi_status[7:4] == mcp_pkg::MS_PRES) aux_voltage_out <= midi_data1;
                default:
                    if (midi_status[7:4] == mcp_pkg::MS_CC
                        && midi_data1 == mcp_pkg::aux_ctrl(prm[mcp_pkg::S_AUX])) // RULE17
                        aux_voltage_out <= midi_data2;
            endcase
        end
    end

    // wishbone slave: one wait state, unmapped reads zero
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign woff    = wb_adr_i - mcp_pkg::ADR_PBASE;
    assign bus_wr  = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i >= mcp_pkg::ADR_PBASE
                     && woff[7:2] < 6'(mcp_pkg::NSLOT) && woff[1:0] == 2'h0;
    always_comb begin
        next_rdata = 32'h0;
        if (wb_adr_i == mcp_pkg::ADR_STATUS)
            next_rdata = {17'h0, ready, level, menu, param, 3'h0, fine};
        else if (wb_adr_i == mcp_pkg::ADR_OUTS)
            next_rdata = {20'h0, gate_out, clock_out, reset_out, gate_core, 1'b0, pitch_note};
        else if (wb_adr_i >= mcp_pkg::ADR_PBASE && woff[7:2] < 6'(mcp_pkg::NSLOT) && woff[1:0] == 2'h0)
            next_rdata = {24'h0, prm[woff[5:2]]};
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) wb_dat_o <= next_rdata;
        end
    end

    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    property p_powerup;
        $rose(ready) |-> $past(power_cnt) == 32'(POWERUP_CYCLES - 1);
    endproperty
    a_powerup: assert property (p_powerup) else $error("ready early"); // RULE1
    property p_top_nowrap;
        ready && level == mcp_pkg::LVL_TOP && inc_p && !ent_p && menu == mcp_pkg::MENU_LAST
            |=> menu == mcp_pkg::MENU_LAST;
    endproperty
    a_top_nowrap: assert property (p_top_nowrap) else $error("menu wrapped"); // RULE3
    property p_param_nowrap;
        ready && level == mcp_pkg::LVL_PARAM && dec_p && !esc_p && !ent_p && param == 4'h0 |=> param == 4'h0;
    endproperty
    a_param_nowrap: assert property (p_param_nowrap) else $error("param wrapped"); // RULE4
    property p_sat;
        ready && level == mcp_pkg::LVL_VALUE && inc_p && !bus_req && prm[cur] == mcp_pkg::slot_max(cur)
            |=> prm[$past(cur)] == $past(prm[cur]);
    endproperty
    a_sat: assert property (p_sat) else $error("value passed max"); // RULE22
    property p_esc;
        ready && level == mcp_pkg::LVL_VALUE && esc_p |=> level == mcp_pkg::LVL_PARAM;
    endproperty
    a_esc: assert property (p_esc) else $error("escape failed"); // RULE6
    property p_chan;
        midi_valid && midi_status[7:4] == mcp_pkg::MS_ON && midi_status[3:0] != chan_idx[3:0]
            |=> held == $past(held);
    endproperty
    a_chan: assert property (p_chan) else $error("foreign channel taken"); // RULE9
    property p_retrig;
        note_on && held != 128'h0 && prm[mcp_pkg::S_RTRG] != 8'h0 |=> !gate_core [*8];
    endproperty
    a_retrig: assert property (p_retrig) else $error("no retrigger gap"); // RULE19
    property p_clkdiv;
        wrap |=> pulse_cnt == 32'(CLKPULSE_CYCLES) ##1 clock_led;
    endproperty
    a_clkdiv: assert property (p_clkdiv) else $error("clock pulse missing"); // RULE21
    property p_high;
        !prm[mcp_pkg::S_MODE][0] && held != 128'h0 |=> pitch_note == $past(hi_note);
    endproperty
    a_high: assert property (p_high) else $error("not highest note"); // RULE13
    c_edit: cover property (level == mcp_pkg::LVL_VALUE && inc_p);
    c_fine: cover property (fine && level == mcp_pkg::LVL_VALUE);
    c_clock: cover property (wrap);
endmodule // mcp_menu_params
`default_nettype wire

// ===== design/mcp_pkg.sv
// mcp_pkg: constants, types and slot tables of the menu controller
// assumes a 200 MHz system clock
`default_nettype none
package mcp_pkg;
    localparam int CLK_HZ      = 200_000_000;
    localparam int CYC_PER_MS  = CLK_HZ / 1000;
    localparam int POWERUP_MS  = 1000;
    localparam int HOLD_MS     = 3000;
    localparam int REPEAT_MS   = 50;
    localparam int CLKPULSE_MS = 1;
    localparam int POWERUP_CYC  = POWERUP_MS * CYC_PER_MS;
    localparam int HOLD_CYC     = HOLD_MS * CYC_PER_MS;
    localparam int REPEAT_CYC   = REPEAT_MS * CYC_PER_MS;
    localparam int CLKPULSE_CYC = CLKPULSE_MS * CYC_PER_MS;
    // register byte addresses
    localparam logic [7:0] ADR_STATUS = 8'h00;
    localparam logic [7:0] ADR_OUTS   = 8'h04;
    localparam logic [7:0] ADR_PBASE  = 8'h40;
    // parameter slots
    localparam logic [3:0] S_CHAN = 4'h0, S_REF = 4'h1, S_GLIDE = 4'h2, S_BEND = 4'h3;
    localparam logic [3:0] S_MODE = 4'h4, S_CURVE = 4'h5, S_GAINC = 4'h6, S_GAINF = 4'h7;
    localparam logic [3:0] S_OFFC = 4'h8, S_OFFF = 4'h9, S_AUX = 4'ha, S_GPOL = 4'hb;
    localparam logic [3:0] S_RTRG = 4'hc, S_CDIV = 4'hd, S_CPOL = 4'he;
    localparam int NSLOT = 15;
    localparam logic [2:0] MENU_LAST = 3'h6;
    // midi status nibbles and realtime bytes
    localparam logic [3:0] MS_OFF = 4'h8, MS_ON = 4'h9, MS_CC = 4'hb, MS_PRES = 4'hd, MS_BEND = 4'he;
    localparam logic [7:0] RT_CLK = 8'hf8, RT_START = 8'hfa, RT_CONT = 8'hfb, RT_STOP = 8'hfc;
    localparam logic [7:0] AUX_CC0 = 8'h03;
    typedef enum logic [2:0] {
        LVL_TOP   = 3'b001,
        LVL_PARAM = 3'b010,
        LVL_VALUE = 3'b100
    } mcp_level_t;
    function automatic logic [7:0] slot_default(input logic [3:0] s);
        case (s)
            S_CHAN:  slot_default = 8'h01;
            S_REF:   slot_default = 8'h18;
            S_BEND:  slot_default = 8'h0c;
            S_CURVE: slot_default = 8'h01;
            S_GAINC, S_GAINF, S_OFFC, S_OFFF: slot_default = 8'h3f;
            S_CDIV:  slot_default = 8'h01;
            default: slot_default = 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] slot_min(input logic [3:0] s);
        case (s)
            S_CHAN, S_CDIV: slot_min = 8'h01;
            S_REF:          slot_min = 8'h0c;
            default:        slot_min = 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] slot_max(input logic [3:0] s);
        case (s)
            S_CHAN:  slot_max = 8'h0f;
            S_REF:   slot_max = 8'h48;
            S_GLIDE: slot_max = 8'h64;
            S_BEND:  slot_max = 8'h3c;
            S_GAINC, S_GAINF, S_OFFC, S_OFFF: slot_max = 8'h7e;
            S_AUX:   slot_max = 8'h0a;
            S_RTRG:  slot_max = 8'h14;
            S_CDIV:  slot_max = 8'h3d;
            default: slot_max = 8'h01;
        endcase
    endfunction
    function automatic logic [7:0] clamp(input logic [3:0] s, input logic [7:0] v);
        if (v < slot_min(s)) clamp = slot_min(s);
        else if (v > slot_max(s)) clamp = slot_max(s);
        else clamp = v;
    endfunction
    // parameters per top menu; lfo, store, init and version open nothing here
    function automatic logic [3:0] param_count(input logic [2:0] m);
        case (m)
            3'h0:    param_count = 4'h9;
            3'h1,
            3'h2:    param_count = 4'h2;
            default: param_count = 4'h0;
        endcase
    endfunction
    function automatic logic [3:0] slot_of(input logic [2:0] m, input logic [3:0] p, input logic f);
        case (m)
            3'h0: begin
                if (p == 4'h6) slot_of = f ? S_GAINF : S_GAINC;
                else if (p == 4'h7) slot_of = f ? S_OFFF : S_OFFC;
                else if (p == 4'h8) slot_of = S_AUX;
                else slot_of = p;
            end
            3'h1:    slot_of = S_GPOL + p;
            default: slot_of = S_CDIV + p;
        endcase
    endfunction
    // controller numbers offered as aux sources
    function automatic logic [6:0] aux_ctrl(input logic [7:0] a);
        case (a)
            8'h03:   aux_ctrl = 7'h01;
            8'h04:   aux_ctrl = 7'h02;
            8'h05:   aux_ctrl = 7'h04;
            8'h06:   aux_ctrl = 7'h07;
            8'h07:   aux_ctrl = 7'h0a;
            8'h08:   aux_ctrl = 7'h0b;
            8'h09:   aux_ctrl = 7'h10;
            default: aux_ctrl = 7'h11;
        endcase
    endfunction
endpackage
`default_nettype wire

// ===== design/mcp_button.sv
// mcp_button: button synchroniser, press pulse and held-key repeat
// assumes an active-high asynchronous pin, debounced outside
`default_nettype none
module mcp_button #(
    parameter int HOLD_CYCLES   = mcp_pkg::HOLD_CYC,
    parameter int REPEAT_CYCLES = mcp_pkg::REPEAT_CYC
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic pin,
    output logic      press
);
    logic        sync1;
    logic        sync2;
    logic        prev;
    logic        accel;
    logic [31:0] hold_cnt;
    logic [31:0] rep_cnt;
    // two-stage synchroniser and edge history
    always_ff @(posedge clk) begin
        if (reset) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev  <= 1'b0;
        end else begin
            sync1 <= pin;
            sync2 <= sync1;
            prev  <= sync2;
        end
    end
    // long hold switches to accelerated stepping
    always_ff @(posedge clk) begin
        if (reset || !sync2) begin
            hold_cnt <= 32'h0;
            accel    <= 1'b0;
        end else if (hold_cnt == 32'(HOLD_CYCLES - 1)) begin
            accel <= 1'b1; // RULE5
        end else begin
            hold_cnt <= hold_cnt + 32'h1;
        end
    end
    // repeat period while accelerated
    always_ff @(posedge clk) begin
        if (reset || !accel || rep_cnt == 32'(REPEAT_CYCLES - 1)) rep_cnt <= 32'h0;
        else rep_cnt <= rep_cnt + 32'h1;
    end
    assign press = (sync2 && !prev) || (accel && rep_cnt == 32'(REPEAT_CYCLES - 1)); // RULE5
endmodule // mcp_button
`default_nettype wire

// ===== tb/mcp_midi_src.sv
// mcp_midi_src: stand-in for the midi sender, one decoded message per strobe
// assumes the system clock; data lines scramble once the strobe is gone
`default_nettype none
module mcp_midi_src (
    output logic       midi_valid,
    output logic [7:0] midi_status,
    output logic [6:0] midi_data1,
    output logic [6:0] midi_data2,
    input  wire logic  clk
);
    timeunit 1ns;
    timeprecision 1ps;
    // quiet lines at time zero
    initial begin
        midi_valid = 1'b0;
        midi_status = 8'h00;
        midi_data1 = 7'h00;
        midi_data2 = 7'h00;
    end
    // gap+1 idle cycles, one strobe, then inverted junk so stale data never matches
    task automatic send(input int gap, input logic [7:0] s, input logic [6:0] a, input logic [6:0] b);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        midi_valid <= 1'b1;
        midi_status <= s;
        midi_data1 <= a;
        midi_data2 <= b;
        @(posedge clk);
        midi_valid <= 1'b0;
        midi_status <= ~s;
        midi_data1 <= ~a;
        midi_data2 <= ~b;
    endtask
endmodule // mcp_midi_src
`default_nettype wire

// ===== tb/mcp_menu_params_tb.sv
// mcp_menu_params_tb: bus, button and midi sequences with expected values
// assumes shortened counts: power-up 20 cycles, hold 40, repeat 8
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module mcp_menu_params_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, reset, cyc, stb, we, wb_ack_o, midi_valid;
    logic        ready, show_version, gate_led, clock_led, reset_led, gate_out, clock_out, reset_out;
    logic [7:0]  adr, midi_status;
    logic [31:0] wdat, rd, wb_dat_o;
    logic [3:0]  btn, sel;
    logic [6:0]  midi_data1, midi_data2, pitch_note, aux_voltage_out;
    logic [13:0] pitch_bend;
    logic [2:0]  menu_level;
    int          num_errors, n_checks;
    logic [7:0]  dflt [15] = '{8'h01, 8'h18, 8'h00, 8'h0c, 8'h00, 8'h01, 8'h3f, 8'h3f,
                              8'h3f, 8'h3f, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
    // address, written value, value read back
    logic [23:0] clp [8] = '{24'h40100f, 24'h400001, 24'h444948, 24'h486564,
                             24'h4c3d3c, 24'h587f7e, 24'h701514, 24'h743e3d};
    mcp_menu_params #(.POWERUP_CYCLES(20), .HOLD_CYCLES(40), .REPEAT_CYCLES(8), .MS_CYCLES(10),
        .CLKPULSE_CYCLES(4)) dut (.clk, .reset, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o, .btn_pins(btn),
        .midi_valid, .midi_status, .midi_data1, .midi_data2, .ready, .show_version, .gate_led,
        .clock_led, .reset_led, .pitch_note, .pitch_bend, .aux_voltage_out, .gate_out, .clock_out,
        .reset_out, .menu_level);
    mcp_midi_src src (.clk, .midi_valid, .midi_status, .midi_data1, .midi_data2);
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // one classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, 24'h0, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) num_errors++;
        rd = wb_dat_o;
        {cyc, stb, we} <= 3'b000;
    endtask
    // short presses, well under the hold time
    task automatic press(input int k, input int times);
        repeat (times) begin
            @(posedge clk);
            btn[k] <= 1'b1;
            repeat (6) @(posedge clk);
            btn[k] <= 1'b0;
            repeat (6) @(posedge clk);
        end
    endtask
    task automatic wrap_up;
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (6000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
    // main sequence
    initial begin
        {reset, cyc, stb, we, adr, wdat, btn, sel} = {4'b1000, 8'h00, 32'h0, 4'h0, 4'h1};
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        src.send(2, 8'h90, 7'd40, 7'd90);
        repeat (4) @(posedge clk);
        `CHK({ready, show_version, pitch_note, pitch_bend}, {2'b01, 7'h00, 14'h2000})
        repeat (16) @(posedge clk);
        `CHK({ready, show_version, gate_led}, 3'b101)
        for (int i = 0; i < 15; i++) begin
            wb(1'b0, 8'h40 + 8'(4 * i), 8'h00);
            `CHK(rd[7:0], dflt[i])
        end
        wb(1'b0, 8'h20, 8'h00);
        `CHK(rd, 32'h0)
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, clp[i][23:16], clp[i][15:8]);
            wb(1'b0, clp[i][23:16], 8'h00);
            `CHK(rd[7:0], clp[i][7:0])
        end
        for (int i = 0; i < 15; i++) wb(1'b1, 8'h40 + 8'(4 * i), dflt[i]);
        // top level: no wrap at either end
        press(1, 1);
        wb(1'b0, 8'h00, 8'h00);
        `CHK({menu_level, rd[10:8]}, 6'b001000)
        press(0, 7);
        wb(1'b0, 8'h00, 8'h00);
        `CHK(rd[10:8], 3'h6)
        press(1, 6);
        press(2, 1);
        `CHK(menu_level, 3'b010)
        press(0, 9);
        wb(1'b0, 8'h00, 8'h00);
        `CHK(rd[7:4], 4'h8)
        press(1, 9);
        press(2, 1);
        `CHK(menu_level, 3'b100)
        press(0, 1);
        wb(1'b0, 8'h40, 8'h00);
        `CHK(rd[7:0], 8'h02)
        press(1, 3);
        wb(1'b0, 8'h40, 8'h00);
        `CHK(rd[7:0], 8'h01)
        wb(1'b1, 8'h40, 8'h0f);
        press(0, 1);
        wb(1'b0, 8'h40, 8'h00);
        `CHK(rd[7:0], 8'h0f)
        wb(1'b1, 8'h40, 8'h01);
        press(3, 1);
        `CHK(menu_level, 3'b010)
        press(3, 1);
        `CHK(menu_level, 3'b001)
        // note priority, channel filter, aux and polarity
        src.send(0, 8'h90, 7'd60, 7'd100);
        src.send(0, 8'h90, 7'd50, 7'd80);
        src.send(0, 8'h91, 7'd70, 7'd90);
        repeat (2) @(posedge clk);
        `CHK({pitch_note, gate_out, aux_voltage_out}, {7'd60, 1'b1, 7'd80})
        wb(1'b1, 8'h68, 8'h01);
        src.send(0, 8'he0, 7'h11, 7'h55);
        repeat (2) @(posedge clk);
        `CHK({aux_voltage_out, pitch_bend}, {7'h55, 14'h2a91})
        wb(1'b1, 8'h50, 8'h01);
        wb(1'b1, 8'h70, 8'h01);
        src.send(3, 8'h90, 7'd55, 7'd70);
        repeat (2) @(posedge clk);
        `CHK({pitch_note, gate_out}, {7'd55, 1'b0})
        repeat (12) @(posedge clk);
        `CHK(gate_out, 1'b1)
        wb(1'b1, 8'h6c, 8'h01);
        repeat (2) @(posedge clk);
        `CHK(gate_out, 1'b0)
        src.send(0, 8'hf8, 7'h00, 7'h00);
        repeat (2) @(posedge clk);
        `CHK({clock_led, clock_out}, 2'b11)
        src.send(0, 8'hfc, 7'h00, 7'h00);
        repeat (2) @(posedge clk);
        `CHK({reset_out, reset_led}, 2'b11)
        src.send(0, 8'hfa, 7'h00, 7'h00);
        repeat (2) @(posedge clk);
        `CHK(reset_out, 1'b0)
        // divide by three: third tick gives the pulse
        wb(1'b1, 8'h74, 8'h03);
        repeat (2) src.send(0, 8'hf8, 7'h00, 7'h00);
        repeat (6) @(posedge clk);
        `CHK(clock_led, 1'b0)
        src.send(0, 8'hf8, 7'h00, 7'h00);
        repeat (2) @(posedge clk);
        `CHK(clock_led, 1'b1)
        wrap_up();
    end
endmodule // mcp_menu_params_tb
`default_nettype wire
